// >>> hostport_pkg.sv
package hostport_pkg;
  // bus mode and strobe style straps
  localparam logic MODE_SEPARATE = 1'b0;
  localparam logic MODE_MUXED = 1'b1;
  localparam logic STYLE_RDWR = 1'b0;
  localparam logic STYLE_DSRW = 1'b1;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  localparam int NUM_PORTS = 4;
  // timing, in ns, and derived cycle counts at 100 MHz
  localparam int CLK_PERIOD_NS = 10;
  localparam int PHASE_NS = 40;
  localparam int PHASE_CYC_RAW = (PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PHASE_CYC = (PHASE_CYC_RAW < 1) ? 1 : PHASE_CYC_RAW;
  localparam int RESET_PULSE_NS = 100;
  localparam int RESET_CYC_RAW = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_CYC = (RESET_CYC_RAW < 1) ? 1 : RESET_CYC_RAW;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] ADDR_RESET = 8'h00;
  localparam logic [3:0] SEL_IDLE = 4'hf;
endpackage

// >>> phase_timer.sv
`timescale 1ns/10ps
// one-cycle tick after each phase of the bus cycle
module phase_timer #(
  parameter int COUNT = 4
) (
  input wire logic REF_CLK_IN,
  input wire logic RESET_IN,
  input wire logic run_in,
  output logic tick_out
);
  logic [7:0] cnt_ff;

  // restart whenever idle so every phase lasts the full count
  always_ff @(posedge REF_CLK_IN) begin
    if (RESET_IN || !run_in || tick_out) begin
      cnt_ff <= 8'h00;
    end else begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end

  assign tick_out = run_in && (cnt_ff == 8'(COUNT - 1));
endmodule

// >>> hostport_master.sv
`timescale 1ns/10ps
module hostport_master
  import hostport_pkg::*;
(
  input wire logic REF_CLK_IN,
  input wire logic RESET_IN,
  input wire logic MUX_MODE_IN,
  input wire logic STYLE_IN,
  input wire logic REQ_IN,
  input wire logic REQ_WRITE_IN,
  input wire logic [1:0] REQ_PORT_IN,
  input wire logic [hostport_pkg::ADDR_W-1:0] REQ_ADDR_IN,
  input wire logic [hostport_pkg::DATA_W-1:0] REQ_WDATA_IN,
  input wire logic DEV_RESET_REQ_IN,
  output logic BUSY_OUT,
  output logic DONE_OUT,
  output logic [hostport_pkg::DATA_W-1:0] RDATA_OUT,
  output logic IRQ_OUT,
  output logic MUX_PIN_OUT,
  output logic STRAP_PIN_OUT,
  output logic [6:0] LOW_ADDR_OUT,
  output logic TOP_ADDR_OUT,
  output logic RD_DS_OUT,
  output logic WR_RW_OUT,
  output logic [3:0] SELECT_N_OUT,
  output logic RESET_AND_FLOAT_OUT,
  input wire logic [hostport_pkg::DATA_W-1:0] BUS_IN,
  output logic [hostport_pkg::DATA_W-1:0] BUS_OUT,
  output logic BUS_OE_OUT,
  input wire logic INT_N_IN
);
  import hostport_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ALE = 3'b001,
    ST_SETUP = 3'b010,
    ST_STROBE = 3'b011,
    ST_HOLD = 3'b100,
    ST_RESET = 3'b101
  } state_e;

  state_e state_ff;
  logic tick;
  logic write_ff;
  logic mux_ff;
  logic style_ff;
  logic [1:0] port_ff;
  logic [7:0] addr_ff;
  logic [7:0] wdata_ff;
  logic [7:0] rst_cnt_ff;
  logic [7:0] bus_s1_ff;
  logic [7:0] bus_s2_ff;
  logic int_s1_ff;
  logic int_s2_ff;
  logic ale_seen_ff;
  logic [7:0] rd_capture_ff;

  // the strobe active level depends on mode and style
  function automatic logic strobe_level(input logic style, input logic mux, input logic on);
    if (style == STYLE_DSRW && mux == MODE_MUXED) begin
      strobe_level = on; // data strobe active high when multiplexed
    end else begin
      strobe_level = !on; // read, write and data strobes active low
    end
  endfunction

  phase_timer #(.COUNT(PHASE_CYC)) u_timer (
    .REF_CLK_IN(REF_CLK_IN),
    .RESET_IN(RESET_IN),
    .run_in(state_ff != ST_IDLE && state_ff != ST_RESET),
    .tick_out(tick)
  );

  // data pins and interrupt come from the device's domain, so two flops each
  always_ff @(posedge REF_CLK_IN) begin
    if (RESET_IN) begin
      bus_s1_ff <= DATA_RESET;
      bus_s2_ff <= DATA_RESET;
      int_s1_ff <= 1'b1;
      int_s2_ff <= 1'b1;
    end else begin
      bus_s1_ff <= BUS_IN;
      bus_s2_ff <= bus_s1_ff;
      int_s1_ff <= INT_N_IN;
      int_s2_ff <= int_s1_ff;
    end
  end

  // interrupt output is high while the device holds its interrupt pin low
  always_ff @(posedge REF_CLK_IN) begin
    if (RESET_IN) begin
      IRQ_OUT <= 1'b0;
    end else begin
      IRQ_OUT <= !int_s2_ff;
    end
  end

  // cycle sequencer; a write ends with a hold phase after the strobe release
  always_ff @(posedge REF_CLK_IN) begin
    if (RESET_IN) begin
      state_ff <= ST_IDLE;
      write_ff <= 1'b0;
      mux_ff <= MODE_SEPARATE;
      style_ff <= STYLE_RDWR;
      port_ff <= 2'h0;
      addr_ff <= ADDR_RESET;
      wdata_ff <= DATA_RESET;
      rst_cnt_ff <= 8'h00;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          if (DEV_RESET_REQ_IN) begin
            state_ff <= ST_RESET;
            rst_cnt_ff <= 8'h00;
          end else if (REQ_IN) begin
            write_ff <= REQ_WRITE_IN;
            mux_ff <= MUX_MODE_IN;
            style_ff <= STYLE_IN;
            port_ff <= REQ_PORT_IN;
            addr_ff <= REQ_ADDR_IN;
            wdata_ff <= REQ_WDATA_IN;
            state_ff <= MUX_MODE_IN ? ST_ALE : ST_SETUP;
          end
        end
        ST_ALE: if (tick) state_ff <= ST_SETUP;
        ST_SETUP: if (tick) state_ff <= ST_STROBE;
        ST_STROBE: if (tick) state_ff <= ST_HOLD;
        ST_HOLD: if (tick) state_ff <= ST_IDLE;
        ST_RESET: begin
          // pin held high a fixed time, then released for normal use
          if (rst_cnt_ff == 8'(RESET_CYC - 1)) begin
            state_ff <= ST_IDLE;
          end else begin
            rst_cnt_ff <= rst_cnt_ff + 8'h01;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // pin drive, registered so every pin comes from a flop
  always_ff @(posedge REF_CLK_IN) begin
    if (RESET_IN) begin
      MUX_PIN_OUT <= MODE_SEPARATE;
      STRAP_PIN_OUT <= STYLE_RDWR;
      LOW_ADDR_OUT <= 7'h00;
      TOP_ADDR_OUT <= 1'b0;
      RD_DS_OUT <= 1'b1;
      WR_RW_OUT <= 1'b1;
      SELECT_N_OUT <= SEL_IDLE;
      RESET_AND_FLOAT_OUT <= 1'b0;
      BUS_OUT <= DATA_RESET;
      BUS_OE_OUT <= 1'b0;
      ale_seen_ff <= 1'b0;
    end else begin
      MUX_PIN_OUT <= mux_ff;
      STRAP_PIN_OUT <= style_ff;
      RESET_AND_FLOAT_OUT <= (state_ff == ST_RESET); // rising edge clears registers
      // low address held low when multiplexed
      LOW_ADDR_OUT <= (mux_ff == MODE_MUXED) ? 7'h00 : addr_ff[6:0];
      // top bit, or latch strobe; low for the first address cycle so the latch
      // always sees a rising edge, even when the top bit was left high
      ale_seen_ff <= (state_ff == ST_ALE);
      TOP_ADDR_OUT <= (mux_ff == MODE_MUXED) ? (state_ff == ST_ALE && ale_seen_ff) : addr_ff[7];
      // one select only, and only around the access
      SELECT_N_OUT <= (state_ff == ST_SETUP || state_ff == ST_STROBE || state_ff == ST_HOLD)
                      ? ~(4'h1 << port_ff) : SEL_IDLE;
      if (style_ff == STYLE_RDWR) begin
        // separate strobes
        RD_DS_OUT <= strobe_level(style_ff, mux_ff, state_ff == ST_STROBE && !write_ff);
        WR_RW_OUT <= strobe_level(style_ff, mux_ff, state_ff == ST_STROBE && write_ff);
      end else begin
        // data strobe plus direction line, high for read
        RD_DS_OUT <= strobe_level(style_ff, mux_ff, state_ff == ST_STROBE);
        WR_RW_OUT <= !write_ff || state_ff == ST_IDLE || state_ff == ST_RESET;
      end
      // address phase then write data; released for reads, device drives
      BUS_OE_OUT <= (mux_ff == MODE_MUXED && state_ff == ST_ALE) ||
                    (write_ff && (state_ff == ST_SETUP || state_ff == ST_STROBE ||
                                  state_ff == ST_HOLD));
      BUS_OUT <= (state_ff == ST_ALE) ? addr_ff : wdata_ff;
    end
  end

  // handshake to the user side; read data sampled before strobe release
  // the device floats the bus once the strobe ends, so the synchronised byte
  // is caught at the end of the strobe phase and handed over with done
  always_ff @(posedge REF_CLK_IN) begin
    if (RESET_IN) begin
      BUSY_OUT <= 1'b0;
      DONE_OUT <= 1'b0;
      RDATA_OUT <= DATA_RESET;
      rd_capture_ff <= DATA_RESET;
    end else begin
      BUSY_OUT <= (state_ff != ST_IDLE) || REQ_IN || DEV_RESET_REQ_IN;
      DONE_OUT <= (state_ff == ST_HOLD) && tick;
      if (state_ff == ST_STROBE && tick && !write_ff) begin
        rd_capture_ff <= bus_s2_ff; // strobe still asserted here
      end
      if (state_ff == ST_HOLD && tick && !write_ff) begin
        RDATA_OUT <= rd_capture_ff;
      end
    end
  end

  a_one_select: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN)
    $countones(~SELECT_N_OUT) <= 1)
    else $error("more than one select low");
  a_mux_low_addr: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN)
    MUX_PIN_OUT |-> LOW_ADDR_OUT == 7'h00)
    else $error("low address not held low in multiplexed mode");
  a_read_no_drive: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN)
    (state_ff == ST_STROBE && !write_ff) |=> !BUS_OE_OUT)
    else $error("host drives bus during read");
  a_write_strobe_low: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN)
    (state_ff == ST_STROBE && write_ff && style_ff == STYLE_RDWR) |=> !WR_RW_OUT)
    else $error("write strobe not low");
  a_ds_high_mux: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN)
    (state_ff == ST_STROBE && style_ff == STYLE_DSRW && mux_ff) |=> RD_DS_OUT)
    else $error("data strobe not high in multiplexed mode");
  a_ale_phase: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN)
    (state_ff == ST_ALE && mux_ff && ale_seen_ff) |=> (TOP_ADDR_OUT && BUS_OE_OUT))
    else $error("address not latched in multiplexed phase");
  a_ale_low_first: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN)
    (state_ff == ST_ALE && mux_ff && !ale_seen_ff) |=> (!TOP_ADDR_OUT && BUS_OE_OUT))
    else $error("latch strobe not low before its rising edge");
  a_write_data_hold: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN)
    (state_ff == ST_HOLD && write_ff) |=> (BUS_OE_OUT && BUS_OUT == wdata_ff))
    else $error("write data not held past strobe");
  a_reset_release: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN)
    $rose(RESET_AND_FLOAT_OUT) |-> ##[1:20] !RESET_AND_FLOAT_OUT)
    else $error("reset/float pin held too long");
  a_irq_follow: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN)
    (!int_s2_ff) |=> IRQ_OUT)
    else $error("interrupt not reported");
  a_mode_pin: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN)
    (state_ff == ST_SETUP) |=> (MUX_PIN_OUT == mux_ff && STRAP_PIN_OUT == style_ff))
    else $error("mode pins wrong");
  a_reset_edge: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN)
    (state_ff == ST_RESET) |=> RESET_AND_FLOAT_OUT)
    else $error("reset pin not raised");
  a_style_dir: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN)
    (state_ff == ST_STROBE && style_ff == STYLE_DSRW) |=> (WR_RW_OUT == !write_ff))
    else $error("direction line wrong");
endmodule

// >>> quad_device_model.sv
`timescale 1ns/10ps
// behavioural four-channel device on the far side of the host port
module quad_device_model (
  input wire logic mux_in,
  input wire logic strap_in,
  input wire logic [6:0] low_addr_in,
  input wire logic top_addr_in,
  input wire logic rd_ds_in,
  input wire logic wr_rw_in,
  input wire logic [3:0] select_n_in,
  input wire logic reset_and_float_in,
  input wire logic [7:0] bus_in,
  input wire logic int_event_in,
  output logic [7:0] rdata_out,
  output logic drive_out,
  output logic int_n_out,
  output logic low_addr_err_out
);
  logic [7:0] mem [4][256];
  logic [7:0] latched;
  logic [7:0] addr;
  logic [1:0] ch;
  logic sel;
  logic strobe_act;
  logic read_act;
  // decode; lowest active select wins if the host ever selects two
  always_comb begin
    ch = select_n_in[0] ? (select_n_in[1] ? (select_n_in[2] ? 2'h3 : 2'h2) : 2'h1) : 2'h0;
    sel = (select_n_in != 4'hf);
    strobe_act = (strap_in && mux_in) ? rd_ds_in : !rd_ds_in;
    read_act = strobe_act && (strap_in ? wr_rw_in : 1'b1);
    addr = mux_in ? latched : {top_addr_in, low_addr_in};
    drive_out = sel && read_act && !reset_and_float_in;
    rdata_out = mem[ch][addr];
    int_n_out = !(int_event_in && !reset_and_float_in); // released means pulled up
  end
  // address capture; 1 ns latch delay so the bus settles after the edge
  always @(posedge top_addr_in) if (mux_in) #1 latched = bus_in;
  // separate-strobe write ends on the write strobe rising
  always @(posedge wr_rw_in) if (!strap_in && sel) mem[ch][addr] = bus_in;
  // data-strobe write ends when the strobe goes inactive
  always @(negedge strobe_act) if (strap_in && sel && !wr_rw_in) mem[ch][addr] = bus_in;
  // register set clears on the rising edge
  always @(posedge reset_and_float_in) begin
    for (int c = 0; c < 4; c++) for (int a = 0; a < 256; a++) mem[c][a] = 8'h00;
  end
  // sticky flag: host left the low address inputs up in multiplexed mode
  initial low_addr_err_out = 1'b0;
  always @(low_addr_in or sel or mux_in) begin
    if (mux_in && sel && low_addr_in != 7'h00) low_addr_err_out = 1'b1;
  end
endmodule

// >>> quad_port_parallel_host_interface_tb.sv
`timescale 1ns/10ps
module quad_port_parallel_host_interface_tb;
  import hostport_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic mux_mode = 1'b0;
  logic style = 1'b0;
  logic req = 1'b0;
  logic req_write = 1'b0;
  logic [1:0] req_port = 2'h0;
  logic [7:0] req_addr = 8'h00;
  logic [7:0] req_wdata = 8'h00;
  logic dev_rst_req = 1'b0;
  logic int_event = 1'b0;
  logic busy, done, irq, mux_pin, strap_pin, top_addr, rd_ds, wr_rw, rf, bus_oe, int_n;
  logic dev_drive, low_err;
  logic [7:0] rdata, bus_out, bus_in, dev_data;
  logic [7:0] float_pat = 8'h00;
  logic [6:0] low_addr;
  logic [3:0] sel_n;
  int err_total = 0;
  int tests_run = 0;
  int cycles = 0;
  // undriven bus shows a changing pattern, never the last value
  assign bus_in = bus_oe ? bus_out : (dev_drive ? dev_data : float_pat);
  always #5 ref_clk = ~ref_clk;
  hostport_master dut_u (.REF_CLK_IN(ref_clk), .RESET_IN(rst), .MUX_MODE_IN(mux_mode),
    .STYLE_IN(style), .REQ_IN(req), .REQ_WRITE_IN(req_write), .REQ_PORT_IN(req_port),
    .REQ_ADDR_IN(req_addr), .REQ_WDATA_IN(req_wdata), .DEV_RESET_REQ_IN(dev_rst_req),
    .BUSY_OUT(busy), .DONE_OUT(done), .RDATA_OUT(rdata), .IRQ_OUT(irq), .MUX_PIN_OUT(mux_pin),
    .STRAP_PIN_OUT(strap_pin), .LOW_ADDR_OUT(low_addr), .TOP_ADDR_OUT(top_addr),
    .RD_DS_OUT(rd_ds), .WR_RW_OUT(wr_rw), .SELECT_N_OUT(sel_n), .RESET_AND_FLOAT_OUT(rf),
    .BUS_IN(bus_in), .BUS_OUT(bus_out), .BUS_OE_OUT(bus_oe), .INT_N_IN(int_n));
  quad_device_model dev_u (.mux_in(mux_pin), .strap_in(strap_pin), .low_addr_in(low_addr),
    .top_addr_in(top_addr), .rd_ds_in(rd_ds), .wr_rw_in(wr_rw), .select_n_in(sel_n),
    .reset_and_float_in(rf), .bus_in(bus_in), .int_event_in(int_event), .rdata_out(dev_data),
    .drive_out(dev_drive), .int_n_out(int_n), .low_addr_err_out(low_err));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    if (err_total == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // cycle ceiling, and a watch for both ends driving the bus at once
  always @(negedge ref_clk) begin
    float_pat <= float_pat + 8'h3b;
    cycles <= cycles + 1;
    if (bus_oe === 1'b1 && dev_drive === 1'b1) check(8'h01, 8'h00);
    if (cycles == 6000) begin
      err_total++;
      complete_run();
    end
  end
  // one access; waits for the completion pulse under a bound
  task automatic access(input logic wr, input logic [1:0] port, input logic [7:0] addr,
      input logic [7:0] wdata, output logic [7:0] got);
    int n;
    @(negedge ref_clk);
    check({7'h00, busy}, 8'h00);
    req = 1'b1;
    req_write = wr;
    req_port = port;
    req_addr = addr;
    req_wdata = wdata;
    @(negedge ref_clk);
    check({7'h00, busy}, 8'h01);
    req = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 40) begin
      @(negedge ref_clk);
      n++;
    end
    check({7'h00, done}, 8'h01);
    got = rdata;
  endtask
  // every bus mode and strobe style, distinct data in each channel
  task automatic mode_sweep();
    logic [7:0] got;
    for (int m = 0; m < 4; m++) begin
      mux_mode = m[1];
      style = m[0];
      for (int p = 0; p < 4; p++) access(1'b1, 2'(p), 8'(8'h81 + m), 8'(8'h3c + 17 * p + 64 * m), got);
      for (int p = 0; p < 4; p++) begin
        access(1'b0, 2'(p), 8'(8'h81 + m), 8'h00, got);
        check(got, 8'(8'h3c + 17 * p + 64 * m));
      end
    end
    check({7'h00, low_err}, 8'h00);
  endtask
  // interrupt follows the pin; reset pulse clears registers and floats the pin
  task automatic reset_irq();
    logic [7:0] got;
    int n;
    int_event = 1'b1;
    repeat (5) @(negedge ref_clk);
    check({7'h00, irq}, 8'h01);
    dev_rst_req = 1'b1;
    @(negedge ref_clk);
    dev_rst_req = 1'b0;
    n = 0;
    while (rf !== 1'b1 && n < 10) begin
      @(negedge ref_clk);
      n++;
    end
    n = 0;
    while (rf === 1'b1 && n < 40) begin
      check({7'h00, int_n}, 8'h01);
      check({7'h00, bus_oe}, 8'h00);
      @(negedge ref_clk);
      n++;
    end
    check(8'(n), 8'(RESET_CYC));
    int_event = 1'b0;
    repeat (5) @(negedge ref_clk);
    check({7'h00, irq}, 8'h00);
    access(1'b0, 2'h2, 8'h84, 8'h00, got);
    check(got, 8'h00);
  endtask
  initial begin
    repeat (3) @(negedge ref_clk);
    rst = 1'b0;
    mode_sweep();
    reset_irq();
    complete_run();
  end
endmodule
